// ==== hw/pmcp_control_pins.sv ====
// power-controller pin logic: interrupt, shutdown/restart, wake, button, power good
`timescale 1ns/1ps
module pmcp_control_pins #(
  parameter int unsigned RESTART_CYCLES = pmcp_pkg::RESTART_DELAY_CYC
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           hw_shutdown_in_n,
  input  wire logic                           button_in_n,
  input  wire logic                           power_on_request_in,
  input  wire pmcp_pkg::pmcp_rails_t          rail_ok_in,
  input  wire logic [pmcp_pkg::EXT_IRQ_W-1:0] ext_irq_event,
  input  wire logic [pmcp_pkg::IRQ_W-1:0]     irq_mask,
  input  wire logic                           irq_read,
  output logic      [pmcp_pkg::IRQ_W-1:0]     irq_flags,
  output logic                                irq_out_n_level,
  output logic                                irq_out_n_oe_n,
  output logic                                wake_out_n_level,
  output logic                                wake_out_n_oe_n,
  output logic                                rails_good_out,
  output pmcp_pkg::pmcp_rails_t               rail_enable,
  output logic                                defaults_restore
);
  import pmcp_pkg::*;

  // --------------------------------------------------------------------
  // input synchronisation
  // --------------------------------------------------------------------
  logic [SYNC_W-1:0]    sync_s;
  logic                 shut_n_s;
  logic                 button_n_s;
  logic                 pwr_req_s;
  logic [NUM_RAILS-1:0] rail_ok_s;
  logic                 button_n_d_reg;
  logic                 button_press;

  pmcp_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({rail_ok_in, power_on_request_in, button_in_n, hw_shutdown_in_n}),
    .sync_out (sync_s)
  );

  assign shut_n_s   = sync_s[SYNC_SHUT];
  assign button_n_s = sync_s[SYNC_BUTTON];
  assign pwr_req_s  = sync_s[SYNC_PWR_REQ];
  assign rail_ok_s  = sync_s[SYNC_RAIL_LO +: NUM_RAILS];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      button_n_d_reg <= 1'b1;
    end else begin
      button_n_d_reg <= button_n_s;
    end
  end

  // no debounce: a bouncing switch may raise several presses
  assign button_press = button_n_d_reg && !button_n_s;

  // --------------------------------------------------------------------
  // power state machine
  // --------------------------------------------------------------------
  localparam logic [CNT_W-1:0]      RESTART_LAST = CNT_W'(RESTART_CYCLES - 1);
  localparam logic [STEP_W-1:0]     STEP_LAST    = STEP_W'(SEQ_STEP_CYC - 1);
  localparam logic [RAIL_IDX_W-1:0] RAIL_LAST    = RAIL_IDX_W'(NUM_RAILS - 1);

  pmcp_state_t           state_reg;
  pmcp_state_t           state_next;
  logic [CNT_W-1:0]      restart_cnt_reg;
  logic [STEP_W-1:0]     step_cnt_reg;
  logic [RAIL_IDX_W-1:0] rail_idx_reg;
  logic [NUM_RAILS-1:0]  rails_reg;
  logic                  step_done;
  logic                  power_on_event;

  assign step_done      = (step_cnt_reg == STEP_LAST);
  assign power_on_event = (state_next == ST_SEQ) && (state_reg != ST_SEQ);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (pwr_req_s || button_press) begin
          state_next = ST_SEQ;
        end
      end
      ST_SHUT: begin
        if (shut_n_s) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (restart_cnt_reg == RESTART_LAST) begin
          state_next = ST_SEQ;
        end
      end
      ST_SEQ: begin
        if (step_done && rail_idx_reg == RAIL_LAST) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (!pwr_req_s) begin
          state_next = ST_OFF;
        end
      end
    endcase
    if (!shut_n_s) begin
      state_next = ST_SHUT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != ST_WAIT) begin
      restart_cnt_reg <= '0;
    end else begin
      restart_cnt_reg <= restart_cnt_reg + 1'b1;
    end
  end

  // one rail per step, bucks first, then the linear regulators
  always_ff @(posedge clk) begin
    if (!rst_n || state_next != ST_SEQ) begin
      step_cnt_reg <= '0;
      rail_idx_reg <= '0;
    end else if (state_reg == ST_SEQ && step_done) begin
      step_cnt_reg <= '0;
      rail_idx_reg <= rail_idx_reg + 1'b1;
    end else if (state_reg == ST_SEQ) begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rails_reg <= RAILS_RST;
    end else if (state_next == ST_SHUT || state_next == ST_OFF || state_next == ST_WAIT) begin
      rails_reg <= RAILS_RST;
    end else if (state_reg == ST_SEQ && step_done) begin
      rails_reg[rail_idx_reg] <= 1'b1;
    end
  end

  assign rail_enable = pmcp_rails_t'(rails_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      defaults_restore <= 1'b0;
    end else begin
      defaults_restore <= (state_reg == ST_SHUT) && (state_next == ST_WAIT);
    end
  end

  // --------------------------------------------------------------------
  // power good and wake
  // --------------------------------------------------------------------
  logic                  rails_good_next;
  logic [STEP_W-1:0]     wake_cnt_reg;

  assign rails_good_next = (state_next == ST_ON) && (&rails_reg) && (&rail_ok_s);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rails_good_out <= 1'b0;
    end else begin
      rails_good_out <= rails_good_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_next == ST_SHUT) begin
      wake_cnt_reg <= '0;
    end else if (power_on_event) begin
      wake_cnt_reg <= STEP_W'(WAKE_PULSE_CYC);
    end else if (wake_cnt_reg != '0) begin
      wake_cnt_reg <= wake_cnt_reg - 1'b1;
    end
  end

  assign wake_out_n_level = 1'b0;
  assign wake_out_n_oe_n  = (wake_cnt_reg == '0);

  // --------------------------------------------------------------------
  // interrupt flags
  // --------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic             irq_drive_reg;

  always_comb begin
    irq_set                 = '0;
    irq_set[IRQ_BUTTON]     = button_press;
    irq_set[IRQ_RAIL_FAULT] = rails_good_out && !rails_good_next && shut_n_s;
    irq_set[IRQ_EXT_LO +: EXT_IRQ_W] = ext_irq_event;
  end

  // a set in the read cycle survives the clear
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg == ST_SHUT) begin
      irq_flags <= IRQ_FLAGS_RST;
    end else if (irq_read) begin
      irq_flags <= irq_set;
    end else begin
      irq_flags <= irq_flags | irq_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_drive_reg <= 1'b0;
    end else begin
      irq_drive_reg <= |(irq_flags & ~irq_mask) && shut_n_s;
    end
  end

  assign irq_out_n_level = 1'b0;
  assign irq_out_n_oe_n  = !irq_drive_reg;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  property p_irq_assert;
    @(posedge clk) disable iff (!rst_n)
      (|(irq_flags & ~irq_mask) && shut_n_s) |=> !irq_out_n_oe_n;
  endproperty
  a_irq_assert: assert property (p_irq_assert) else $error("irq pin not pulled");

  property p_irq_clear;
    @(posedge clk) disable iff (!rst_n)
      (irq_read && irq_set == '0) |=> (irq_flags == '0) ##1 irq_out_n_oe_n;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared by read");

  property p_irq_mask;
    @(posedge clk) disable iff (!rst_n)
      ((irq_flags & ~irq_mask) == '0) |=> irq_out_n_oe_n;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked flag drove irq");

  property p_shutdown;
    @(posedge clk) disable iff (!rst_n)
      !shut_n_s |=> (rails_reg == '0 && irq_out_n_oe_n && wake_out_n_oe_n && !rails_good_out);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("outputs on during shutdown");

  property p_restart_hold;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_WAIT && shut_n_s && restart_cnt_reg != RESTART_LAST)
        |=> (state_reg == ST_WAIT && rails_reg == '0);
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart delay cut short");

  property p_restart_go;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_WAIT && shut_n_s && restart_cnt_reg == RESTART_LAST)
        |=> state_reg == ST_SEQ;
  endproperty
  a_restart_go: assert property (p_restart_go) else $error("no power-up after delay");

  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      (power_on_event && shut_n_s) |=> !wake_out_n_oe_n ##1 (!wake_out_n_oe_n || !$past(shut_n_s));
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse missing");

  property p_button;
    @(posedge clk) disable iff (!rst_n)
      (button_press && state_reg != ST_SHUT) |=> irq_flags[IRQ_BUTTON];
  endproperty
  a_button: assert property (p_button) else $error("button press not flagged");

  property p_good;
    @(posedge clk) disable iff (!rst_n)
      !(&rail_ok_s) |=> !rails_good_out;
  endproperty
  a_good: assert property (p_good) else $error("power good with rail out");

  property p_seq_start;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_OFF && pwr_req_s && shut_n_s)
        |=> state_reg == ST_SEQ ##[1:300] (rails_reg[0] || !shut_n_s);
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("sequence did not start");

  property p_sync;
    @(posedge clk) disable iff (!rst_n)
      ($past(rst_n, 2) && $past(rst_n)) |-> (shut_n_s == $past(hw_shutdown_in_n, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("shutdown not two-flop synced");

endmodule

// ==== hw/pmcp_pkg.sv ====
// constants, field layouts and types shared by the control-pin logic
package pmcp_pkg;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 250_000_000;
  localparam int unsigned CLK_MHZ           = CLK_HZ / 1_000_000;
  localparam int unsigned RESTART_DELAY_S   = 1;
  localparam int unsigned RESTART_DELAY_CYC = RESTART_DELAY_S * CLK_HZ;
  // least times, rounded up to whole cycles
  localparam int unsigned SEQ_STEP_NS       = 1000;
  localparam int unsigned SEQ_STEP_CYC      = (SEQ_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_PULSE_NS     = 1000;
  localparam int unsigned WAKE_PULSE_CYC    = (WAKE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W             = 28;
  localparam int unsigned STEP_W            = 8;

  // --------------------------------------------------------------------
  // rails and interrupt flags
  // --------------------------------------------------------------------
  localparam int unsigned NUM_RAILS      = 7;
  localparam int unsigned RAIL_IDX_W     = 3;
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned EXT_IRQ_W      = 2;
  localparam int unsigned IRQ_BUTTON     = 0;
  localparam int unsigned IRQ_RAIL_FAULT = 1;
  localparam int unsigned IRQ_EXT_LO     = 2;
  localparam logic [IRQ_W-1:0] IRQ_FLAGS_RST = 4'h0;
  localparam logic [NUM_RAILS-1:0] RAILS_RST = 7'h00;

  // --------------------------------------------------------------------
  // input synchroniser layout
  // --------------------------------------------------------------------
  localparam int unsigned SYNC_W        = 3 + NUM_RAILS;
  localparam int unsigned SYNC_SHUT     = 0;
  localparam int unsigned SYNC_BUTTON   = 1;
  localparam int unsigned SYNC_PWR_REQ  = 2;
  localparam int unsigned SYNC_RAIL_LO  = 3;
  // idle levels: shutdown and button released, no request, rails not ok
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h003;

  typedef struct packed {
    logic [3:0] linear;
    logic [2:0] buck;
  } pmcp_rails_t;

  typedef enum logic [4:0] {
    ST_OFF  = 5'h01,
    ST_SHUT = 5'h02,
    ST_WAIT = 5'h04,
    ST_SEQ  = 5'h08,
    ST_ON   = 5'h10
  } pmcp_state_t;

endpackage

// ==== hw/pmcp_sync.sv ====
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module pmcp_sync #(
  parameter int unsigned          W       = 1,
  parameter logic [W-1:0]         RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_reg[i] <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end else begin
        meta_reg[i] <= async_in[i];
        sync_out[i] <= meta_reg[i];
      end
    end
  end

endmodule

// ==== test/pmcp_partner.sv ====
// host processor and push-button model facing the control pins
`timescale 1ns/1ps
module pmcp_partner #(
  parameter int unsigned LAG = 3
) (
  input  wire logic                  clk,
  input  wire logic                  press,
  input  wire logic                  want_power,
  input  wire logic [6:0]            fault,
  input  wire logic                  irq_wire_n,
  input  wire pmcp_pkg::pmcp_rails_t rail_enable,
  output logic                       button_in_n,
  output logic                       power_on_request_in,
  output pmcp_pkg::pmcp_rails_t      rail_ok_in,
  output logic                       irq_read
);
  import pmcp_pkg::*;
  logic [6:0] en_d [LAG];
  int         ack_wait = 0;

  // switch closes to ground, so a press reads low
  // follows the bench's falling-edge controls at once, so no same-edge race
  assign button_in_n         = ~press;
  assign power_on_request_in = want_power;

  // a regulator comes good a few cycles after its enable; a fault pulls it out
  always @(negedge clk) begin
    en_d[0] <= rail_enable;
    for (int i = 1; i < LAG; i++) begin
      en_d[i] <= en_d[i-1];
    end
  end

  assign rail_ok_in = en_d[LAG-1] & rail_enable & ~fault;

  // host reads the flag register a random while after the pin goes low
  always @(negedge clk) begin
    irq_read <= 1'b0;
    if (irq_wire_n !== 1'b0 || irq_read) begin
      ack_wait <= 0;
    end else if (ack_wait == 0) begin
      ack_wait <= 1 + $urandom_range(7);
    end else if (ack_wait == 1) begin
      irq_read <= 1'b1;
      ack_wait <= 0;
    end else begin
      ack_wait <= ack_wait - 1;
    end
  end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the control-pin logic
`timescale 1ns/1ps
module tb;
  import pmcp_pkg::*;
  localparam int unsigned RST_CYC = 20;
  localparam int unsigned LAG     = 3;
  localparam int S_RAILS = 0, S_GOOD = 1, S_IRQ = 2, S_WAKE = 3, S_RST = 4, S_FLAGS = 5;
  logic                 clk, rst_n, shut_n, press, want_power, irq_read, button_n, req;
  logic [6:0]           fault;
  logic [EXT_IRQ_W-1:0] ext_ev;
  logic [IRQ_W-1:0]     mask, flags;
  logic                 irq_o, irq_oe_n, wake_o, wake_oe_n, good, restore;
  pmcp_rails_t          rail_ok, rails;
  int                   fail_count, checked;
  // both open-drain pins have pull-ups
  wire                  irq_wire_n  = irq_oe_n ? 1'b1 : irq_o;
  wire                  wake_wire_n = wake_oe_n ? 1'b1 : wake_o;

  pmcp_control_pins #(.RESTART_CYCLES(RST_CYC)) u_dut (
    .clk(clk), .rst_n(rst_n), .hw_shutdown_in_n(shut_n), .button_in_n(button_n),
    .power_on_request_in(req), .rail_ok_in(rail_ok), .ext_irq_event(ext_ev),
    .irq_mask(mask), .irq_read(irq_read), .irq_flags(flags), .irq_out_n_level(irq_o),
    .irq_out_n_oe_n(irq_oe_n), .wake_out_n_level(wake_o), .wake_out_n_oe_n(wake_oe_n),
    .rails_good_out(good), .rail_enable(rails), .defaults_restore(restore));

  pmcp_partner #(.LAG(LAG)) u_host (
    .clk(clk), .press(press), .want_power(want_power), .fault(fault),
    .irq_wire_n(irq_wire_n), .rail_enable(rails), .button_in_n(button_n),
    .power_on_request_in(req), .rail_ok_in(rail_ok), .irq_read(irq_read));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // --------------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] pick(input int sel);
    case (sel)
      S_RAILS: return {25'h0, rails};
      S_GOOD:  return {31'h0, good};
      S_IRQ:   return {31'h0, irq_wire_n};
      S_WAKE:  return {31'h0, wake_wire_n};
      S_RST:   return {31'h0, restore};
      default: return {28'h0, flags};
    endcase
  endfunction

  // a wait that runs out is a mismatch and ends the run
  task automatic wait_val(input int sel, input logic [31:0] exp, input int bound);
    int n;
    n = 0;
    while (pick(sel) !== exp) begin
      @(negedge clk);
      n++;
      if (n > bound) begin
        check(pick(sel), exp);
        give_verdict();
      end
    end
    checked++;
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  initial begin
    int               b, w;
    logic [IRQ_W-1:0] m;
    rst_n = 1'b0;
    shut_n = 1'b1;
    press = 1'b0;
    want_power = 1'b0;
    fault = 7'h00;
    ext_ev = 2'h0;
    mask = 4'h0;
    fail_count = 0;
    checked = 0;
    void'($urandom(76));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check({irq_oe_n, wake_oe_n, good, restore, rails, flags}, {4'b1100, 11'h000});
    // first two passes: plain, then the event's own mask bit set
    for (int i = 0; i < 8; i++) begin
      b = $urandom_range(1);
      m = (i < 2) ? 4'(i << (b + 2)) : 4'($urandom);
      mask = m;
      ext_ev = 2'(1 << b);
      @(negedge clk);
      ext_ev = 2'h0;
      check(flags[IRQ_EXT_LO + b], 1'b1);
      if (m[IRQ_EXT_LO + b]) begin
        repeat (6) @(negedge clk);
        check({irq_wire_n, flags[IRQ_EXT_LO + b]}, 2'b11);
        mask = 4'h0;
      end
      wait_val(S_IRQ, 0, 4);
      wait_val(S_IRQ, 1, 30);
      check(flags, 4'h0);
    end
    // masked from here so flags stay for inspection
    mask = 4'hf;
    want_power = 1'b1;
    fork
      begin
        wait_val(S_WAKE, 0, 8);
        w = 0;
        while (wake_wire_n === 1'b0 && w < 400) begin
          @(negedge clk);
          w++;
        end
        check(w >= WAKE_PULSE_CYC - 1 && w <= WAKE_PULSE_CYC + 1, 1);
      end
      for (int k = 0; k < NUM_RAILS; k++) begin
        wait_val(S_RAILS, (32'h1 << (k + 1)) - 1, SEQ_STEP_CYC + 20);
      end
    join
    wait_val(S_GOOD, 1, LAG + 10);
    fault = 7'(1 << $urandom_range(6));
    wait_val(S_GOOD, 0, LAG + 8);
    fault = 7'h00;
    wait_val(S_GOOD, 1, LAG + 10);
    ext_ev = 2'h1;
    @(negedge clk);
    ext_ev = 2'h0;
    shut_n = 1'b0;
    wait_val(S_RAILS, 0, 6);
    @(negedge clk);
    check({good, irq_oe_n, wake_oe_n, flags}, {3'b011, 4'h0});
    press = 1'b1;
    repeat (8) @(negedge clk);
    check({rails, flags}, 11'h000);
    press = 1'b0;
    repeat (4) @(negedge clk);
    shut_n = 1'b1;
    wait_val(S_RST, 1, 6);
    w = 0;
    while (wake_wire_n !== 1'b0 && w < RST_CYC + 10) begin
      @(negedge clk);
      w++;
    end
    check({w >= RST_CYC - 2, wake_wire_n, 25'(rails)}, {2'b10, 25'h0});
    wait_val(S_RAILS, 32'h7f, 8 * SEQ_STEP_CYC);
    wait_val(S_GOOD, 1, LAG + 10);
    want_power = 1'b0;
    wait_val(S_RAILS, 0, 8);
    wait_val(S_FLAGS, 4'h2, 4);
    check(irq_wire_n, 1'b1);
    mask = 4'h0;
    wait_val(S_IRQ, 0, 4);
    wait_val(S_IRQ, 1, 30);
    mask = 4'hf;
    press = 1'b1;
    repeat (2) @(negedge clk);
    check(flags[IRQ_BUTTON], 1'b0);
    wait_val(S_FLAGS, 4'h1, 6);
    press = 1'b0;
    wait_val(S_RAILS, 32'h1, SEQ_STEP_CYC + 20);
    give_verdict();
  end
endmodule
